/* File: tawf_irq.sv */
`timescale 1ns/1ns
module tawf_irq
  import tawf_pkg::*;
#(
  parameter int P_W = IRQ_W
) (
  input wire logic i_clk_sys,                 // System clock
  input wire logic i_srst,                    // Sync reset, active high
  input wire logic [P_W-1:0] i_set,           // Event pulses
  input wire logic [P_W-1:0] i_clr,           // Bits cleared by a status read
  input wire logic i_mask_we,                 // Mask write strobe
  input wire logic [P_W-1:0] i_mask_wdata,    // Mask write data
  output logic [P_W-1:0] o_status,            // Sticky status
  output logic [P_W-1:0] o_mask,              // Mask register
  output logic o_irq                          // Level interrupt
);

  typedef struct packed {
    logic [P_W-1:0] status;
    logic [P_W-1:0] mask;
  } tawf_irq_st_t;

  tawf_irq_st_t st_r;
  tawf_irq_st_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Set beats clear so an event landing on the read is never lost
  always_comb begin
    st_nxt = st_r;
    st_nxt.status = (st_r.status & ~i_clr) | i_set;
    if (i_mask_we) begin
      st_nxt.mask = i_mask_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_r.status <= '0;
      st_r.mask <= P_W'(IRQ_MASK_RESET);
    end else begin
      st_r <= st_nxt;
    end
  end

  // Status and mask straight from flops; irq is the OR of their AND
  assign o_status = st_r.status;
  assign o_mask = st_r.mask;
  assign o_irq = |(st_r.status & st_r.mask);

endmodule

/* File: tawf_pkg.sv */
package tawf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Counter and mode register layout
  localparam int CNT_W = 8;
  localparam int MODE_W = 4;
  localparam int SEL_W = 3;
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_CLR_BIT = 3;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [2:0] SEL_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: divide ratios are powers of two, held as log2 values
  localparam int PRE_W = 11;
  localparam int NUM_SEL = 8;
  localparam int WDT_DIV_LOG2 = 11;
  localparam int PRE_LOG2 [0:NUM_SEL-1] = '{1, 2, 3, 5, 7, 9, 10, 11};

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog reset pulse length in system clocks
  localparam logic [2:0] RST_PULSE_CYCLES = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // APB register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_INFO = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask layout
  localparam int IRQ_W = 2;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_CLR_BIT = 1;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  typedef enum logic [0:0] {
    TAWF_ST_RUN = 1'b0,
    TAWF_ST_WDRST = 1'b1
  } tawf_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } tawf_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tawf_apb_rsp_t;

endpackage

/* File: tawf_prescaler.sv */
`timescale 1ns/1ns
module tawf_prescaler
  import tawf_pkg::*;
#(
  parameter int P_NUM_SEL = NUM_SEL
) (
  input wire logic i_clk_sys,                 // System clock
  input wire logic i_srst,                    // Sync reset, active high
  output logic [P_NUM_SEL-1:0] o_tick,        // Per-select count enables
  output logic o_wdt_tick                     // Fixed 1/2048 enable
);

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
  } tawf_pre_st_t;

  tawf_pre_st_t st_r;
  tawf_pre_st_t st_nxt;

  // True on the last cycle of a 2^n period
  function automatic logic period_end(input logic [PRE_W-1:0] v, input int n);
    logic [PRE_W-1:0] msk;
    msk = (PRE_W'(1) << n) - PRE_W'(1);
    return &(v | ~msk);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // One free-running divider feeds every tap, so all taps stay in phase
  always_comb begin
    st_nxt = st_r;
    st_nxt.cnt = st_r.cnt + PRE_W'(1);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Taps, one enable pulse per selectable rate
  genvar gi;
  for (gi = 0; gi < P_NUM_SEL; gi++) begin : g_tap
    assign o_tick[gi] = period_end(st_r.cnt, PRE_LOG2[gi]);
  end
  assign o_wdt_tick = period_end(st_r.cnt, WDT_DIV_LOG2);

endmodule

/* File: tawf_timer_a.sv */
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
module tawf_timer_a
  import tawf_pkg::*;
#(
  parameter bit P_WATCHDOG = 1'b0             // Build option: 1 watchdog, 0 free-run
) (
  input wire logic i_clk_sys,                 // System clock, 100 MHz
  input wire logic i_srst,                    // Sync reset, active high
  input wire tawf_apb_req_t i_apb,            // APB request from master
  output tawf_apb_rsp_t o_apb,                // APB answer to master
  output logic o_irq,                         // Level interrupt request
  output logic o_chip_reset                   // Watchdog chip reset request
);

  ////////////////////////////////////////////////////////////////////////////
  // Module state

  typedef struct packed {
    tawf_state_t state;
    logic [SEL_W-1:0] sel;
    logic [CNT_W-1:0] count;
    logic [2:0] rst_cnt;
    logic [31:0] rdata;
    logic ovf;
    logic clr_evt;
  } tawf_main_st_t;

  tawf_main_st_t st_r;
  tawf_main_st_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helpers

  // Full byte address compare; misaligned addresses never match
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  // Any mapped register
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return addr_hit(a, OFS_MODE) || addr_hit(a, OFS_COUNT) ||
           addr_hit(a, OFS_STATUS) || addr_hit(a, OFS_MASK) ||
           addr_hit(a, OFS_INFO);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase decode

  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  logic apb_rd;
  logic mode_wr;
  logic clr_wr;
  logic mask_wr;
  logic status_rd;

  // Writes and read side effects happen only at the access edge
  assign apb_setup = i_apb.psel & ~i_apb.penable;
  assign apb_access = i_apb.psel & i_apb.penable;
  assign apb_wr = apb_access & i_apb.pwrite;
  assign apb_rd = apb_access & ~i_apb.pwrite;
  assign mode_wr = apb_wr & addr_hit(i_apb.paddr, OFS_MODE);
  assign clr_wr = mode_wr & i_apb.pwdata[MODE_CLR_BIT];
  assign mask_wr = apb_wr & addr_hit(i_apb.paddr, OFS_MASK);
  assign status_rd = apb_rd & addr_hit(i_apb.paddr, OFS_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and interrupt unit

  logic [NUM_SEL-1:0] pre_tick;
  logic wdt_tick;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;

  tawf_prescaler #(
    .P_NUM_SEL(NUM_SEL)
  ) u_pre (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .o_tick(pre_tick),
    .o_wdt_tick(wdt_tick)
  );

  // Event pulses come from flops, in the same cycle the count moves; status sets one cycle later
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_OVF_BIT] = st_r.ovf;
    irq_set[IRQ_CLR_BIT] = st_r.clr_evt;
  end

  // Clear only what the master was shown at setup; later events survive
  assign irq_clr = status_rd ? st_r.rdata[IRQ_W-1:0] : '0;

  tawf_irq #(
    .P_W(IRQ_W)
  ) u_irq (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_set(irq_set),
    .i_clr(irq_clr),
    .i_mask_we(mask_wr),
    .i_mask_wdata(i_apb.pwdata[IRQ_W-1:0]),
    .o_status(irq_status),
    .o_mask(irq_mask),
    .o_irq(o_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counting enable

  logic cnt_tick;
  logic [CNT_W-1:0] cnt_inc;

  // Watchdog ignores the select field; no software path changes the mode
  assign cnt_tick = P_WATCHDOG ? wdt_tick : pre_tick[st_r.sel];
  assign cnt_inc = st_r.count + CNT_W'(1);

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux, sampled in the setup phase

  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_hit(i_apb.paddr, OFS_MODE)) begin
      rd_mux = 32'h0000_0000;
    end else if (addr_hit(i_apb.paddr, OFS_COUNT)) begin
      rd_mux = {24'h00_0000, st_r.count};
    end else if (addr_hit(i_apb.paddr, OFS_STATUS)) begin
      rd_mux = {30'h0000_0000, irq_status};
    end else if (addr_hit(i_apb.paddr, OFS_MASK)) begin
      rd_mux = {30'h0000_0000, irq_mask};
    end else if (addr_hit(i_apb.paddr, OFS_INFO)) begin
      rd_mux = {31'h0000_0000, P_WATCHDOG};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    st_nxt = st_r;
    st_nxt.ovf = 1'b0;
    st_nxt.clr_evt = 1'b0;

    // Capture read data early so the access phase needs no wait state
    if (apb_setup) begin
      st_nxt.rdata = rd_mux;
    end

    // Select field only; bit 3 is an action and is never kept
    if (mode_wr) begin
      st_nxt.sel = i_apb.pwdata[MODE_SEL_LSB +: SEL_W];
    end

    case (st_r.state)
      TAWF_ST_RUN: begin
        if (clr_wr) begin
          // Clear beats a tick in the same cycle, so no overflow follows
          st_nxt.count = CNT_RESET;
          st_nxt.clr_evt = 1'b1;
        end else if (cnt_tick) begin
          st_nxt.count = cnt_inc;
          if (cnt_inc == CNT_MAX) begin
            if (P_WATCHDOG) begin
              // Chip reset starts the cycle the count lands on FF
              st_nxt.state = TAWF_ST_WDRST;
              st_nxt.rst_cnt = RST_PULSE_CYCLES;
            end else begin
              st_nxt.ovf = 1'b1;
            end
          end
        end
      end
      TAWF_ST_WDRST: begin
        // Hold the reset request for a fixed pulse, then restart at zero
        st_nxt.count = CNT_RESET;
        st_nxt.rst_cnt = st_r.rst_cnt - 3'h1;
        if (st_r.rst_cnt == 3'h1) begin
          st_nxt.state = TAWF_ST_RUN;
        end
      end
      default: begin
        st_nxt.state = TAWF_ST_RUN;
      end
    endcase
  end

  // Free-run wrap from FF to 00 is the plain 8-bit increment

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_r.state <= TAWF_ST_RUN;
      st_r.sel <= SEL_RESET;
      st_r.count <= CNT_RESET;
      st_r.rst_cnt <= 3'h0;
      st_r.rdata <= 32'h0000_0000;
      st_r.ovf <= 1'b0;
      st_r.clr_evt <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Zero-wait slave; error only for unmapped or misaligned addresses
  assign o_apb.pready = 1'b1;
  assign o_apb.pslverr = apb_access & ~addr_ok(i_apb.paddr);
  assign o_apb.prdata = st_r.rdata;

  // Watchdog build only: software must clear in time to keep this low
  assign o_chip_reset = (st_r.state == TAWF_ST_WDRST);

endmodule

/* File: tawf_timer_a_props.sv */
`timescale 1ns/1ns
module tawf_timer_a_props
  import tawf_pkg::*;
#(
  parameter bit P_WATCHDOG = 1'b0
) (
  input wire logic i_clk_sys,  // Clock
  input wire logic i_srst,  // Reset
  input wire tawf_apb_req_t i_apb,  // Bus request
  input wire tawf_apb_rsp_t o_apb,  // Bus answer
  input wire logic o_irq,  // Interrupt
  input wire logic o_chip_reset  // Chip reset
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  ////////////////////////////////////////
  // Access phase, and reads of one register
  sequence s_acc;
    i_apb.psel && i_apb.penable;
  endsequence
  sequence s_rd(logic [7:0] a);
    s_acc ##0 !i_apb.pwrite && i_apb.paddr == a;
  endsequence
  property p_ready;
    s_acc |-> o_apb.pready;
  endproperty
  property p_mode_wo;
    s_rd(OFS_MODE) |-> o_apb.prdata == 32'h0;
  endproperty
  property p_info;
    s_rd(OFS_INFO) |-> o_apb.prdata == {31'h0, P_WATCHDOG};
  endproperty
  property p_cnt_w;
    s_rd(OFS_COUNT) |-> o_apb.prdata[31:8] == 24'h0;
  endproperty
  property p_bad;
    s_acc ##0 i_apb.paddr > OFS_INFO |-> o_apb.pslverr && o_apb.prdata == 32'h0;
  endproperty
  property p_rst;
    $past(i_srst) |-> !o_irq && !o_chip_reset;
  endproperty
  property p_mode;
    o_chip_reset |-> P_WATCHDOG;
  endproperty
  // Pulse is exactly four cycles wide
  property p_pulse;
    $rose(o_chip_reset) |-> o_chip_reset [*4] ##1 !o_chip_reset;
  endproperty
  // Sticky: only a status read or mask write lowers it
  property p_irq_fall;
    $fell(o_irq) |-> $past(i_apb.psel && i_apb.penable &&
      (i_apb.paddr == OFS_STATUS || i_apb.paddr == OFS_MASK));
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_mode_wo: assert property (p_mode_wo) else $error("mode readable");
  a_info: assert property (p_info) else $error("info wrong");
  a_cnt_w: assert property (p_cnt_w) else $error("count width");
  a_bad: assert property (p_bad) else $error("bad address answer");
  a_rst: assert property (p_rst) else $error("reset outputs");
  a_mode: assert property (p_mode) else $error("chip reset in free-run");
  a_pulse: assert property (p_pulse) else $error("reset pulse length");
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
endmodule
bind tawf_timer_a tawf_timer_a_props #(.P_WATCHDOG(P_WATCHDOG)) tawf_timer_a_props_inst (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_apb(i_apb), .o_apb(o_apb),
  .o_irq(o_irq), .o_chip_reset(o_chip_reset));

/* File: test_timer_a_watchdog_freerun.sv */
`timescale 1ns/1ns
module test_timer_a_watchdog_freerun
  import tawf_pkg::*;
;
  logic i_clk_sys = 1'b0;
  logic i_srst = 1'b1;
  tawf_apb_req_t i_apb = '0;
  tawf_apb_rsp_t o_apb;
  logic o_irq;
  logic o_chip_reset;
  tawf_apb_rsp_t w_apb;
  logic w_chip_reset;
  int mismatches = 0;
  int tests_run = 0;
  int seed = 89085;
  int cycles = 0;
  int rs;
  int rw;
  int n;
  logic [31:0] q;
  logic e;
  logic [31:0] wq;
  logic [7:0] ra [4] = '{OFS_MODE, OFS_STATUS, OFS_MASK, OFS_INFO};

  always #5 i_clk_sys = ~i_clk_sys;

  tawf_timer_a #(.P_WATCHDOG(1'b0)) tawf_timer_a_inst (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_apb(i_apb), .o_apb(o_apb),
    .o_irq(o_irq), .o_chip_reset(o_chip_reset));
  // Watchdog build on the same bus; its answers are kept apart
  if (1'b1) begin : g_wdt
    tawf_timer_a #(.P_WATCHDOG(1'b1)) tawf_timer_a_inst (
      .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_apb(i_apb), .o_apb(w_apb),
      .o_irq(), .o_chip_reset(w_chip_reset));
  end
  ////////////////////////////////////////
  task automatic test_done();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    tests_run++;
    if (g !== x) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, x);
    end
  endtask
  task automatic chk_b(input logic g, input logic x, input string m);
    tests_run++;
    if (g !== x) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %b exp %b", $time, m, g, x);
    end
  endtask
  // One bus transfer; holds the request until pready is seen
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_clk_sys);
    i_apb.penable <= 1'b1;
    do @(posedge i_clk_sys); while (o_apb.pready !== 1'b1);
    q = o_apb.prdata;
    e = o_apb.pslverr;
    wq = w_apb.prdata;
    i_apb.psel <= 1'b0;
    i_apb.penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  // Prescaler phase is unknown, so allow one tick either way
  function automatic logic cnt_ok(input logic [31:0] c, input int l, input int w);
    int t;
    t = (w + 2) >> l;
    return c + 1 >= t && c <= t + 1;
  endfunction
  // Hang guard, well above the expected run
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      test_done();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    xfer(1'b0, OFS_COUNT, 32'h0);
    chk(q, 32'h0, "reset count");
    xfer(1'b1, OFS_MODE, 32'h7);
    foreach (ra[i]) begin
      xfer(1'b0, ra[i], 32'h0);
      chk(q, 32'h0, "reset reg");
    end
    xfer(1'b0, 8'h14, 32'h0);
    chk(q, 32'h0, "unmapped data");
    chk_b(e, 1'b1, "unmapped error");
    $display("test reset done");
    // Every select, each started by a clear
    for (int s = 0; s < NUM_SEL; s++) begin
      xfer(1'b1, OFS_MODE, 32'h8 | s);
      repeat (4 << PRE_LOG2[s]) @(posedge i_clk_sys);
      xfer(1'b0, OFS_COUNT, 32'h0);
      chk_b(cnt_ok(q, PRE_LOG2[s], 4 << PRE_LOG2[s]), 1'b1, "rate");
    end
    repeat (20) begin
      rs = $unsigned($random(seed)) % 3;
      rw = $unsigned($random(seed)) % 200;
      xfer(1'b1, OFS_MODE, 32'h8 | rs);
      repeat (rw) @(posedge i_clk_sys);
      xfer(1'b0, OFS_COUNT, 32'h0);
      chk_b(cnt_ok(q, PRE_LOG2[rs], rw), 1'b1, "random rate");
      xfer(1'b1, OFS_MASK, $random(seed));
    end
    $display("test rates done");
    // Overflow from a clear at the fastest select
    xfer(1'b1, OFS_MASK, 32'h1);
    xfer(1'b0, OFS_STATUS, 32'h0);
    xfer(1'b1, OFS_MODE, 32'h8);
    n = 0;
    while (o_irq !== 1'b1 && n < 600) begin
      @(posedge i_clk_sys);
      n++;
    end
    chk_b(n >= 500 && n <= 515, 1'b1, "overflow time");
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk_b(q[0], 1'b1, "overflow flag");
    xfer(1'b0, OFS_COUNT, 32'h0);
    chk_b(q < 4, 1'b1, "wrap");
    chk_b(o_irq, 1'b0, "irq after read");
    chk_b(o_chip_reset, 1'b0, "no chip reset in free-run");
    $display("test overflow done");
    // Repeated clears keep it from ever overflowing
    repeat (5) begin
      xfer(1'b1, OFS_MODE, 32'h8);
      repeat (300) @(posedge i_clk_sys);
    end
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h2, "event count");
    chk_b(o_irq, 1'b0, "no irq");
    $display("test event done");
    // Watchdog build: fastest select must not matter; timely clears hold off reset
    xfer(1'b0, OFS_INFO, 32'h0);
    chk(wq, 32'h1, "watchdog info");
    repeat (2) begin
      xfer(1'b1, OFS_MODE, 32'h8);
      repeat (4 << WDT_DIV_LOG2) @(posedge i_clk_sys);
      xfer(1'b0, OFS_COUNT, 32'h0);
      chk_b(cnt_ok(wq, WDT_DIV_LOG2, 4 << WDT_DIV_LOG2), 1'b1, "watchdog rate");
      chk_b(w_chip_reset, 1'b0, "watchdog held off");
    end
    $display("test watchdog done");
    test_done();
  end
endmodule
